//--- rtl/pvc_defines.vh
// constants for the pll calibration and counter sync control block
`ifndef PVC_DEFINES_VH
`define PVC_DEFINES_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PVC_IDX_CALCTL 10'h018
`define PVC_IDX_SYNCDLY 10'h019
`define PVC_IDX_UPDATE 10'h232
`define PVC_IDX_STATUS 10'h240

// ****************************************************************
// reset values
// ****************************************************************
`define PVC_RST_CALCTL 8'h06
`define PVC_RST_SYNCDLY 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define PVC_CAL_NOW_BIT 0
`define PVC_CAL_DIV_LSB 1
`define PVC_CAL_DIV_MSB 2
`define PVC_SYNC_MODE_LSB 6
`define PVC_SYNC_MODE_MSB 7
`define PVC_RDLY_LSB 3
`define PVC_RDLY_MSB 5
`define PVC_NDLY_LSB 0
`define PVC_NDLY_MSB 2
`define PVC_UPDATE_BIT 0

// ****************************************************************
// codes and timing counts
// ****************************************************************
`define PVC_DIV_2 2'h0
`define PVC_DIV_4 2'h1
`define PVC_DIV_8 2'h2
`define PVC_DIV_16 2'h3
`define PVC_SYNC_NONE 2'h0
`define PVC_SYNC_ASYNC 2'h1
`define PVC_SYNC_SYNC 2'h2
`define PVC_SYNC_NONE2 2'h3
`define PVC_CAL_STEPS 8'h40
`define PVC_RESP_OKAY 2'h0
`define PVC_RESP_SLVERR 2'h2

`endif

//--- rtl/pvc_cal_div.v
// calibration clock divider driven from the reference clock
`timescale 1ns/10ps
module pvc_cal_div (
	// clock and reset
	input wire mclk_i,
	input wire nrst_i,
	// control
	input wire run_i,
	input wire [1:0] div_sel_i,
	// divided clock and its rising-edge tick
	output reg cal_clk_o,
	output reg tick_o
);
`include "pvc_defines.vh"

	reg [2:0] half_cnt_r; // mclk cycles within one half period
	reg [2:0] half_max; // last count of a half period

	// ****************************************************************
	// half period select: ratio n gives n/2 cycles per half
	// ****************************************************************
	always @* begin
		case (div_sel_i)
			`PVC_DIV_2: half_max = 3'h0;
			`PVC_DIV_4: half_max = 3'h1;
			`PVC_DIV_8: half_max = 3'h3;
			default: half_max = 3'h7; // divide by 16, longest calibration
		endcase
	end

	// ****************************************************************
	// divider: idle low, restarts cleanly each calibration
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_cnt_r <= 3'h0;
			cal_clk_o <= 1'b0;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			half_cnt_r <= 3'h0;
			cal_clk_o <= 1'b0;
			tick_o <= 1'b0;
		end else if (half_cnt_r >= half_max) begin
			// end of half period: flip the divided clock
			half_cnt_r <= 3'h0;
			cal_clk_o <= ~cal_clk_o;
			tick_o <= ~cal_clk_o;
		end else begin
			half_cnt_r <= half_cnt_r + 3'h1;
			tick_o <= 1'b0;
		end
	end
endmodule // pvc_cal_div

//--- rtl/pvc_axil_slave.v
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/10ps
module pvc_axil_slave (
	// clock and reset
	input wire mclk_i,
	input wire nrst_i,
	// write address and data channels
	input wire [11:0] s_axil_awaddr_i,
	input wire s_axil_awvalid_i,
	output reg s_axil_awready_o,
	input wire [31:0] s_axil_wdata_i,
	input wire [3:0] s_axil_wstrb_i,
	input wire s_axil_wvalid_i,
	output reg s_axil_wready_o,
	// write response channel
	output reg [1:0] s_axil_bresp_o,
	output reg s_axil_bvalid_o,
	input wire s_axil_bready_i,
	// read channels
	input wire [11:0] s_axil_araddr_i,
	input wire s_axil_arvalid_i,
	output reg s_axil_arready_o,
	output reg [31:0] s_axil_rdata_o,
	output reg [1:0] s_axil_rresp_o,
	output reg s_axil_rvalid_o,
	input wire s_axil_rready_i,
	// register file side
	output wire wr_en_o,
	output wire [9:0] wr_idx_o,
	output wire [7:0] wr_data_o,
	output wire wr_lane0_o,
	input wire wr_hit_i,
	output wire [9:0] rd_idx_o,
	input wire [31:0] rd_data_i,
	input wire rd_hit_i
);
`include "pvc_defines.vh"

	reg aw_full_r; // write address held
	reg w_full_r; // write data held
	reg [9:0] aw_idx_r; // held word index
	reg [7:0] w_data_r; // held low byte
	reg w_lane0_r; // held strobe of byte lane 0

	// write fires once both halves are held and no answer is pending
	assign wr_en_o = aw_full_r & w_full_r & ~s_axil_bvalid_o;
	assign wr_idx_o = aw_idx_r;
	assign wr_data_o = w_data_r;
	assign wr_lane0_o = w_lane0_r;
	assign rd_idx_o = s_axil_araddr_i[11:2];

	// ****************************************************************
	// write path
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
			s_axil_awready_o <= 1'b1;
			s_axil_wready_o <= 1'b1;
			s_axil_bvalid_o <= 1'b0;
			s_axil_bresp_o <= `PVC_RESP_OKAY;
		end else begin
			// address taken, in any order with data
			if (s_axil_awvalid_i && s_axil_awready_o) begin
				aw_full_r <= 1'b1;
				aw_idx_r <= s_axil_awaddr_i[11:2];
				s_axil_awready_o <= 1'b0;
			end
			// data taken
			if (s_axil_wvalid_i && s_axil_wready_o) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axil_wdata_i[7:0];
				w_lane0_r <= s_axil_wstrb_i[0];
				s_axil_wready_o <= 1'b0;
			end
			// perform the write and answer; unmapped gets slverr
			if (wr_en_o) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axil_bvalid_o <= 1'b1;
				s_axil_bresp_o <= wr_hit_i ? `PVC_RESP_OKAY :
					`PVC_RESP_SLVERR;
			end
			// answer accepted, reopen both channels
			if (s_axil_bvalid_o && s_axil_bready_i) begin
				s_axil_bvalid_o <= 1'b0;
				s_axil_awready_o <= 1'b1;
				s_axil_wready_o <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// read path: data sampled at the address handshake
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axil_arready_o <= 1'b1;
			s_axil_rvalid_o <= 1'b0;
			s_axil_rdata_o <= 32'h00000000;
			s_axil_rresp_o <= `PVC_RESP_OKAY;
		end else if (s_axil_arvalid_i && s_axil_arready_o) begin
			s_axil_arready_o <= 1'b0;
			s_axil_rvalid_o <= 1'b1;
			s_axil_rdata_o <= rd_data_i;
			s_axil_rresp_o <= rd_hit_i ? `PVC_RESP_OKAY :
				`PVC_RESP_SLVERR;
		end else if (s_axil_rvalid_o && s_axil_rready_i) begin
			s_axil_rvalid_o <= 1'b0;
			s_axil_arready_o <= 1'b1;
		end
	end
endmodule // pvc_axil_slave

//--- rtl/pvc_top.v
// pll oscillator calibration, counter sync and path delay control
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pvc_top (
	// clock and reset
	input wire mclk_i,
	input wire nrst_i,
	// axi4-lite write address and data
	input wire [11:0] s_axil_awaddr_i,
	input wire s_axil_awvalid_i,
	output wire s_axil_awready_o,
	input wire [31:0] s_axil_wdata_i,
	input wire [3:0] s_axil_wstrb_i,
	input wire s_axil_wvalid_i,
	output wire s_axil_wready_o,
	// axi4-lite write response
	output wire [1:0] s_axil_bresp_o,
	output wire s_axil_bvalid_o,
	input wire s_axil_bready_i,
	// axi4-lite read
	input wire [11:0] s_axil_araddr_i,
	input wire s_axil_arvalid_i,
	output wire s_axil_arready_o,
	output wire [31:0] s_axil_rdata_o,
	output wire [1:0] s_axil_rresp_o,
	output wire s_axil_rvalid_o,
	input wire s_axil_rready_i,
	// external synchronisation pin
	input wire sync_i,
	// counter reset requests
	output reg ctr_async_rst_o,
	output reg ctr_sync_rst_o,
	// path delay settings
	output reg [2:0] ref_dly_o,
	output reg [2:0] fb_dly_o,
	// calibration
	output wire cal_clk_o,
	output reg cal_busy_o,
	output reg cal_done_o,
	output reg cal_valid_o,
	output reg lock_det_en_o
);
`include "pvc_defines.vh"

	// ****************************************************************
	// state codes
	// ****************************************************************
	localparam ST_IDLE = 2'h0; // waiting for a start
	localparam ST_RUN = 2'h1; // counting calibration clock ticks
	localparam ST_DONE = 2'h2; // finishing, result made valid

	// ****************************************************************
	// declarations
	// ****************************************************************
	wire wr_en; // write strobe from the bus front end
	wire [9:0] wr_idx; // word index of the write
	wire [7:0] wr_data; // low byte of the write data
	wire wr_lane0; // byte lane 0 enabled
	reg wr_hit; // write index is mapped
	wire [9:0] rd_idx; // word index of the read
	reg [31:0] rd_data; // read data for that index
	reg rd_hit; // read index is mapped

	reg [7:0] calctl_buf_r; // buffered calibration control
	reg [7:0] syncdly_buf_r; // buffered sync and delay control
	reg [7:0] calctl_act_r; // active calibration control
	reg [7:0] syncdly_act_r; // active sync and delay control
	reg update_r; // update-all strobe, one cycle

	reg now_prev_r; // active calibrate-now bit one cycle ago
	wire now_act; // active calibrate-now bit
	wire cal_start; // rising edge of the active bit
	wire cal_abort; // falling edge of the active bit

	reg [1:0] state_r; // calibration state
	reg [1:0] state_nxt; // next calibration state
	reg [7:0] step_r; // ticks counted so far
	reg [7:0] step_nxt; // next tick count
	wire cal_tick; // rising edge of the calibration clock
	wire div_run; // divider enable

	reg sync_prev_r; // sync pin one cycle ago
	wire [1:0] sync_mode; // active sync action field

	// ****************************************************************
	// bus front end
	// ****************************************************************
	pvc_axil_slave u_bus (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.s_axil_awaddr_i(s_axil_awaddr_i),
		.s_axil_awvalid_i(s_axil_awvalid_i),
		.s_axil_awready_o(s_axil_awready_o),
		.s_axil_wdata_i(s_axil_wdata_i),
		.s_axil_wstrb_i(s_axil_wstrb_i),
		.s_axil_wvalid_i(s_axil_wvalid_i),
		.s_axil_wready_o(s_axil_wready_o),
		.s_axil_bresp_o(s_axil_bresp_o),
		.s_axil_bvalid_o(s_axil_bvalid_o),
		.s_axil_bready_i(s_axil_bready_i),
		.s_axil_araddr_i(s_axil_araddr_i),
		.s_axil_arvalid_i(s_axil_arvalid_i),
		.s_axil_arready_o(s_axil_arready_o),
		.s_axil_rdata_o(s_axil_rdata_o),
		.s_axil_rresp_o(s_axil_rresp_o),
		.s_axil_rvalid_o(s_axil_rvalid_o),
		.s_axil_rready_i(s_axil_rready_i),
		.wr_en_o(wr_en),
		.wr_idx_o(wr_idx),
		.wr_data_o(wr_data),
		.wr_lane0_o(wr_lane0),
		.wr_hit_i(wr_hit),
		.rd_idx_o(rd_idx),
		.rd_data_i(rd_data),
		.rd_hit_i(rd_hit)
	);

	// ****************************************************************
	// address decode for writes
	// ****************************************************************
	always @* begin
		case (wr_idx)
			`PVC_IDX_CALCTL: wr_hit = 1'b1;
			`PVC_IDX_SYNCDLY: wr_hit = 1'b1;
			`PVC_IDX_UPDATE: wr_hit = 1'b1;
			`PVC_IDX_STATUS: wr_hit = 1'b1; // read only, write ignored
			default: wr_hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// read mux: buffered values, status shows live state
	// ****************************************************************
	always @* begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		case (rd_idx)
			`PVC_IDX_CALCTL: begin
				rd_data = {24'h000000, calctl_buf_r};
			end
			`PVC_IDX_SYNCDLY: begin
				rd_data = {24'h000000, syncdly_buf_r};
			end
			`PVC_IDX_UPDATE: begin
				rd_data = 32'h00000000; // strobe reads zero
			end
			`PVC_IDX_STATUS: begin
				rd_data = {16'h0000, step_r, syncdly_act_r[7:6],
					calctl_act_r[2:1], now_act, cal_done_o,
					cal_valid_o, cal_busy_o};
			end
			default: begin
				rd_hit = 1'b0; // unmapped reads zero with slverr
			end
		endcase
	end

	// ****************************************************************
	// buffered registers and update-all strobe
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			calctl_buf_r <= `PVC_RST_CALCTL;
			syncdly_buf_r <= `PVC_RST_SYNCDLY;
			update_r <= 1'b0;
		end else begin
			update_r <= 1'b0;
			if (wr_en && wr_lane0) begin
				case (wr_idx)
					`PVC_IDX_CALCTL: begin
						// only divider and calibrate-now are kept
						calctl_buf_r <= {5'h00, wr_data[2:0]};
					end
					`PVC_IDX_SYNCDLY: begin
						syncdly_buf_r <= wr_data;
					end
					`PVC_IDX_UPDATE: begin
						update_r <= wr_data[`PVC_UPDATE_BIT];
					end
					default: begin
						update_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// active copies, loaded only by the update-all strobe
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			calctl_act_r <= `PVC_RST_CALCTL;
			syncdly_act_r <= `PVC_RST_SYNCDLY;
		end else if (update_r) begin
			calctl_act_r <= calctl_buf_r;
			syncdly_act_r <= syncdly_buf_r;
		end
	end

	// ****************************************************************
	// edge detect on the active calibrate-now bit
	// ****************************************************************
	assign now_act = calctl_act_r[`PVC_CAL_NOW_BIT];
	assign cal_start = now_act & ~now_prev_r;
	assign cal_abort = ~now_act & now_prev_r;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			now_prev_r <= 1'b0;
		end else begin
			now_prev_r <= now_act;
		end
	end

	// ****************************************************************
	// calibration clock divider
	// ****************************************************************
	assign div_run = (state_r == ST_RUN);

	pvc_cal_div u_div (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.run_i(div_run),
		.div_sel_i(calctl_act_r[`PVC_CAL_DIV_MSB:`PVC_CAL_DIV_LSB]),
		.cal_clk_o(cal_clk_o),
		.tick_o(cal_tick)
	);

	// ****************************************************************
	// calibration sequencer, next state
	// ****************************************************************
	always @* begin
		state_nxt = state_r;
		step_nxt = step_r;
		case (state_r)
			ST_IDLE: begin
				if (cal_start) begin
					state_nxt = ST_RUN;
					step_nxt = 8'h00;
				end
			end
			ST_RUN: begin
				if (cal_abort) begin
					state_nxt = ST_IDLE;
				end else if (cal_tick) begin
					// duration scales with the divide ratio
					step_nxt = step_r + 8'h01;
					if (step_r == `PVC_CAL_STEPS - 8'h01) begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// calibration sequencer, state and outputs
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ST_IDLE;
			step_r <= 8'h00;
			cal_busy_o <= 1'b0;
			cal_done_o <= 1'b0;
			cal_valid_o <= 1'b0;
			lock_det_en_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
			cal_busy_o <= (state_nxt == ST_RUN);
			cal_done_o <= (state_nxt == ST_DONE);
			if (cal_abort || cal_start) begin
				// old result thrown away
				cal_valid_o <= 1'b0;
				lock_det_en_o <= 1'b0;
			end else if (state_nxt == ST_DONE) begin
				// lock detection may proceed only now
				cal_valid_o <= 1'b1;
				lock_det_en_o <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// sync pin action on the reference and feedback counters
	// ****************************************************************
	assign sync_mode = syncdly_act_r[`PVC_SYNC_MODE_MSB:`PVC_SYNC_MODE_LSB];

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_prev_r <= 1'b0;
			ctr_async_rst_o <= 1'b0;
			ctr_sync_rst_o <= 1'b0;
		end else begin
			sync_prev_r <= sync_i;
			// async: held as long as the pin stays asserted
			ctr_async_rst_o <= (sync_mode == `PVC_SYNC_ASYNC) & sync_i;
			// sync: one pulse at the pin's assertion
			ctr_sync_rst_o <= (sync_mode == `PVC_SYNC_SYNC) &
				sync_i & ~sync_prev_r;
		end
	end

	// ****************************************************************
	// path delay settings from the active copy
	// ****************************************************************
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ref_dly_o <= 3'h0;
			fb_dly_o <= 3'h0;
		end else begin
			ref_dly_o <= syncdly_act_r[`PVC_RDLY_MSB:`PVC_RDLY_LSB];
			fb_dly_o <= syncdly_act_r[`PVC_NDLY_MSB:`PVC_NDLY_LSB];
		end
	end
endmodule // pvc_top

//--- verification/pvc_chk_assertions.sv
// assertion checker for the pll calibration and counter sync control block
`timescale 1ns/10ps
module pvc_chk (
	// clock and reset
	input wire mclk_i,
	input wire nrst_i,
	// sync pin and counter reset requests
	input wire sync_i,
	input wire ctr_async_rst_o,
	input wire ctr_sync_rst_o,
	// calibration outputs
	input wire cal_clk_o,
	input wire cal_busy_o,
	input wire cal_done_o,
	input wire cal_valid_o,
	input wire lock_det_en_o,
	// read channel handshake
	input wire s_axil_arvalid_i,
	input wire s_axil_arready_o,
	input wire s_axil_rvalid_o
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	// ****************************************************************
	// properties
	// ****************************************************************
	// lock detection may only run on a held result
	property p_lock_follows_valid;
		lock_det_en_o == cal_valid_o;
	endproperty
	a_lock_follows_valid: assert property (p_lock_follows_valid)
		else $error("lock enable differs from result valid");
	// completion is a single-cycle pulse
	property p_done_single;
		cal_done_o |=> !cal_done_o;
	endproperty
	a_done_single: assert property (p_done_single)
		else $error("done pulse longer than one cycle");
	// completion leaves a held result and an idle sequencer
	property p_done_result;
		cal_done_o |-> ##[0:1] (cal_valid_o && !cal_busy_o);
	endproperty
	a_done_result: assert property (p_done_result)
		else $error("done without valid result and idle");
	// a fresh run throws the old result away
	property p_start_clears;
		$rose(cal_busy_o) |-> ##[0:1] !cal_valid_o;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("old result kept across a new run");
	// divided clock is parked low outside a run
	property p_idle_clk;
		!cal_busy_o [*3] |-> !cal_clk_o;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("calibration clock runs while idle");
	// async counter reset only follows a high pin
	property p_async_cause;
		ctr_async_rst_o |-> $past(sync_i);
	endproperty
	a_async_cause: assert property (p_async_cause)
		else $error("async counter reset without sync pin");
	// sync counter reset is one cycle wide
	property p_sync_pulse;
		ctr_sync_rst_o |=> !ctr_sync_rst_o;
	endproperty
	a_sync_pulse: assert property (p_sync_pulse)
		else $error("sync counter reset wider than one cycle");
	// one mode at a time, never both reset kinds
	property p_reset_excl;
		!(ctr_async_rst_o && ctr_sync_rst_o);
	endproperty
	a_reset_excl: assert property (p_reset_excl)
		else $error("both counter reset kinds active");
	// read answer comes one cycle after the address is taken
	property p_read_latency;
		s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read answer late");
	// a result only becomes valid on the completion pulse
	property p_valid_rise;
		$rose(cal_valid_o) |-> cal_done_o;
	endproperty
	a_valid_rise: assert property (p_valid_rise)
		else $error("result valid without completion");
	// sync counter reset needs a fresh rise of the pin
	property p_sync_cause;
		ctr_sync_rst_o |-> $past(sync_i) && !$past(sync_i, 2);
	endproperty
	a_sync_cause: assert property (p_sync_cause)
		else $error("sync counter reset without pin rising");
endmodule // pvc_chk

//--- verification/test_pll_vco_calibration_and_sync_control.sv
// self-checking bench for the pll calibration and counter sync control
`timescale 1ns/10ps
module test_pll_vco_calibration_and_sync_control;
	// bench-driven inputs
	reg mclk_i, nrst_i, sync_i;
	reg [11:0] s_axil_awaddr_i, s_axil_araddr_i;
	reg [31:0] s_axil_wdata_i;
	reg [3:0] s_axil_wstrb_i;
	reg s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i;
	reg s_axil_arvalid_i, s_axil_rready_i;
	// design outputs
	wire s_axil_awready_o, s_axil_wready_o, s_axil_bvalid_o;
	wire s_axil_arready_o, s_axil_rvalid_o;
	wire [1:0] s_axil_bresp_o, s_axil_rresp_o;
	wire [31:0] s_axil_rdata_o;
	wire ctr_async_rst_o, ctr_sync_rst_o, cal_clk_o, cal_busy_o;
	wire cal_done_o, cal_valid_o, lock_det_en_o;
	wire [2:0] ref_dly_o, fb_dly_o;
	// bench state
	integer fail_count, samples_checked, m, i, na, ns, dur, ne, nd, prev;
	reg [31:0] d;
	reg [1:0] rsp;

	pvc_top u_dut (.mclk_i, .nrst_i, .s_axil_awaddr_i, .s_axil_awvalid_i,
		.s_axil_awready_o, .s_axil_wdata_i, .s_axil_wstrb_i,
		.s_axil_wvalid_i, .s_axil_wready_o, .s_axil_bresp_o,
		.s_axil_bvalid_o, .s_axil_bready_i, .s_axil_araddr_i,
		.s_axil_arvalid_i, .s_axil_arready_o, .s_axil_rdata_o,
		.s_axil_rresp_o, .s_axil_rvalid_o, .s_axil_rready_i, .sync_i,
		.ctr_async_rst_o, .ctr_sync_rst_o, .ref_dly_o, .fb_dly_o,
		.cal_clk_o, .cal_busy_o, .cal_done_o, .cal_valid_o,
		.lock_det_en_o);

	// ****************************************************************
	// tasks
	// ****************************************************************
	// verdict and end of run
	task test_done;
		begin
			$display("checks %0d mismatches %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// a wait ran out: count it and stop
	task tmo;
		begin
			fail_count = fail_count + 1;
			$display("[ERR] t=%0t got %h exp %h (wait ran out)", $time, 0, 1);
			test_done;
		end
	endtask
	// compare and count
	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("[ERR] t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge mclk_i);
		end
	endtask
	// axi4-lite write; response code left in rsp
	task axw(input [11:0] a, input [31:0] v, input [3:0] s);
		reg ok;
		begin
			@(posedge mclk_i);
			s_axil_awaddr_i <= a;
			s_axil_wdata_i <= v;
			s_axil_wstrb_i <= s;
			s_axil_awvalid_i <= 1'b1;
			s_axil_wvalid_i <= 1'b1;
			s_axil_bready_i <= 1'b1;
			ok = 1'b0;
			for (i = 0; i < 50 && !ok; i = i + 1) begin
				@(posedge mclk_i);
				if (s_axil_awvalid_i && s_axil_awready_o === 1'b1)
					s_axil_awvalid_i <= 1'b0;
				if (s_axil_wvalid_i && s_axil_wready_o === 1'b1)
					s_axil_wvalid_i <= 1'b0;
				if (s_axil_bvalid_o === 1'b1) begin
					rsp = s_axil_bresp_o;
					s_axil_bready_i <= 1'b0;
					ok = 1'b1;
				end
			end
			if (!ok)
				tmo;
		end
	endtask
	// axi4-lite read; data in d, response code in rsp
	task axr(input [11:0] a);
		reg ok;
		begin
			@(posedge mclk_i);
			s_axil_araddr_i <= a;
			s_axil_arvalid_i <= 1'b1;
			s_axil_rready_i <= 1'b1;
			ok = 1'b0;
			for (i = 0; i < 50 && !ok; i = i + 1) begin
				@(posedge mclk_i);
				if (s_axil_arvalid_i && s_axil_arready_o === 1'b1)
					s_axil_arvalid_i <= 1'b0;
				if (s_axil_rvalid_o === 1'b1) begin
					d = s_axil_rdata_o;
					rsp = s_axil_rresp_o;
					s_axil_rready_i <= 1'b0;
					ok = 1'b1;
				end
			end
			if (!ok)
				tmo;
		end
	endtask
	// write a buffered register, then make it active
	task wupd(input [11:0] a, input [31:0] v);
		begin
			axw(a, v, 4'hF);
			axw(12'h8C8, 32'h1, 4'hF);
		end
	endtask
	// follow one run: length, divided clock rises, done pulses
	task run_cal;
		reg pc;
		begin
			dur = 0;
			ne = 0;
			nd = 0;
			pc = 1'b0;
			for (i = 0; i < 40 && cal_busy_o !== 1'b1; i = i + 1)
				@(posedge mclk_i);
			if (cal_busy_o !== 1'b1)
				tmo;
			for (i = 0; i < 2200 && cal_busy_o === 1'b1; i = i + 1) begin
				@(posedge mclk_i);
				dur = dur + 1;
				if (cal_clk_o === 1'b1 && pc === 1'b0)
					ne = ne + 1;
				if (cal_done_o === 1'b1)
					nd = nd + 1;
				pc = cal_clk_o;
			end
			if (cal_busy_o !== 1'b0)
				tmo;
			repeat (2) begin
				@(posedge mclk_i);
				if (cal_done_o === 1'b1)
					nd = nd + 1;
			end
		end
	endtask

	// free-running reference clock, 8 ns period
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{nrst_i, sync_i, s_axil_awvalid_i, s_axil_wvalid_i} = 4'h0;
		{s_axil_bready_i, s_axil_arvalid_i, s_axil_rready_i} = 3'h0;
		{s_axil_awaddr_i, s_axil_araddr_i} = 24'h0;
		s_axil_wdata_i = 32'h0;
		s_axil_wstrb_i = 4'h0;
		fail_count = 0;
		samples_checked = 0;
		cyc(16);
		nrst_i <= 1'b1;
		// reset values and map edges
		axr(12'h060);
		chk(d, 32'h06);
		axr(12'h064);
		chk(d, 32'h00);
		axr(12'h900);
		chk(d[5:4], 2'h3);
		chk({ref_dly_o, fb_dly_o}, 6'h00);
		axr(12'h8C8);
		chk(d, 32'h0);
		axr(12'h010);
		chk(d, 32'h0);
		chk(rsp, 2'h2);
		axw(12'h010, 32'hFF, 4'hF);
		chk(rsp, 2'h2);
		// every sync mode, with delays 5 and 3
		for (m = 0; m < 4; m = m + 1) begin
			axw(12'h064, {24'h0, m[1:0], 6'h2B}, 4'hF);
			if (m == 0)
				chk(ref_dly_o, 3'h0);
			axw(12'h8C8, 32'h1, 4'hF);
			chk(rsp, 2'h0);
			cyc(3);
			chk({ref_dly_o, fb_dly_o}, 6'h2B);
			na = 0;
			ns = 0;
			sync_i <= 1'b1;
			for (i = 0; i < 6; i = i + 1) begin
				@(posedge mclk_i);
				na = na + ctr_async_rst_o;
				ns = ns + ctr_sync_rst_o;
			end
			sync_i <= 1'b0;
			cyc(3);
			chk(na != 0, m == 1);
			chk(ns, m == 2);
		end
		// a write with no low byte lane changes nothing
		axw(12'h064, 32'h0, 4'h0);
		axr(12'h064);
		chk(d, 32'hEB);
		// calibration at every divider code; the phase rate suits all
		prev = 0;
		for (m = 0; m < 4; m = m + 1) begin
			wupd(12'h060, {29'h0, m[1:0], 1'b0});
			wupd(12'h060, {29'h0, m[1:0], 1'b1});
			run_cal;
			chk(ne, 32'h40);
			chk(dur >= (63 << (m + 1)) && dur <= (65 << (m + 1)) + 8, 1'b1);
			chk(dur > prev, 1'b1);
			prev = dur;
			chk(nd, 32'h1);
			chk({cal_valid_o, lock_det_en_o}, 2'h3);
			axr(12'h900);
			chk(d[1], 1'b1);
			chk(d[15:2], {8'h40, 2'h3, m[1:0], 2'h2});
			axw(12'h8C8, 32'h1, 4'hF);
			cyc(10);
			chk(cal_busy_o, 1'b0);
			wupd(12'h060, {29'h0, m[1:0], 1'b0});
			cyc(3);
			chk(cal_valid_o, 1'b0);
		end
		// abort in mid-run; nothing else is written during the run
		wupd(12'h060, 32'h7);
		cyc(100);
		chk(cal_busy_o, 1'b1);
		wupd(12'h060, 32'h6);
		cyc(4);
		chk({cal_busy_o, cal_valid_o}, 2'h0);
		test_done;
	end
endmodule // test_pll_vco_calibration_and_sync_control

bind pvc_top pvc_chk u_chk (.mclk_i, .nrst_i, .sync_i, .ctr_async_rst_o,
	.ctr_sync_rst_o, .cal_clk_o, .cal_busy_o, .cal_done_o, .cal_valid_o,
	.lock_det_en_o, .s_axil_arvalid_i, .s_axil_arready_o, .s_axil_rvalid_o);
